// file: rtl/dbg_unit_defines.vh
`ifndef DBG_UNIT_DEFINES_VH
`define DBG_UNIT_DEFINES_VH

// Tile configuration space (config port)
`define CFG_DEBUG_WRITE_PERMISSION   8'h04
`define CFG_DEBUG_INTERRUPT_REQUEST  8'h05
// Processor status space (debug port), base of each bank of four; interrupt type and data are single registers
`define PS_INSTR_BREAK_ADDR          8'h30
`define PS_INSTR_BREAK_CONTROL       8'h40
`define PS_DATA_WATCH_FIRST_ADDR     8'h50
`define PS_DATA_WATCH_SECOND_ADDR    8'h60
`define PS_DATA_WATCH_CONTROL        8'h70
`define PS_RESOURCE_WATCH_MASK       8'h80
`define PS_RESOURCE_WATCH_VALUE      8'h90
`define PS_RESOURCE_WATCH_CONTROL    8'h9c
`define PS_DEBUG_INTERRUPT_TYPE      8'h15
`define PS_DEBUG_INTERRUPT_DATA      8'h16

// Control fields
`define CTL_ENABLE_BIT               0
`define CTL_MODE_BIT                 1
`define CTL_LOADS_BIT                2
`define CTL_THREAD_HI                23
`define CTL_THREAD_LO                16
`define IBC_WRITE_MASK               32'h00ff0003
`define DWC_WRITE_MASK               32'h00ff0007
`define RWC_WRITE_MASK               32'h00ff0003
`define CTL_RESET                    32'h00000000

// Permission and request fields
`define PERM_ALL_BIT                 31
`define PERM_SYS_BIT                 0
`define REQ_RAISE_BIT                0
`define REQ_MODE_BIT                 1

// Access sources
`define SRC_SYSTEM_SWITCH            2'h0
`define SRC_DEBUG_SCRATCH            2'h1
`define SRC_JTAG                     2'h2
`define SRC_LOCAL                    2'h3

// Cause codes
`define CAUSE_INSTR                  3'h3
`define CAUSE_DATA                   3'h4
`define CAUSE_RESOURCE               3'h5

`endif

// file: rtl/dbg_comparator.v
`timescale 1ns/100ps
// One comparator; kind: 0 instruction, 1 data, 2 resource
module dbg_comparator
#(
  parameter KIND = 0
)
(
  input  wire [31:0] ctl,
  input  wire [31:0] first_val,
  input  wire [31:0] second_val,
  input  wire [2:0]  thread,
  input  wire        valid,
  input  wire [31:0] probe,
  input  wire        is_load,
  output reg         hit
);
`include "dbg_unit_defines.vh"

  reg [7:0] threads;
  reg       cond_a;
  reg       cond_b;
  reg       cond;

  always @*
  begin
    threads = ctl[`CTL_THREAD_HI:`CTL_THREAD_LO];
    cond_a  = 1'b0;
    cond_b  = 1'b0;
    cond    = 1'b0;
    if (KIND == 0)
    begin
      cond = ctl[`CTL_MODE_BIT] ? (probe != first_val) : (probe == first_val);
    end
    else if (KIND == 1)
    begin
      cond_a = (probe == first_val);
      cond_b = (probe == second_val);
      cond   = ctl[`CTL_MODE_BIT] ? (cond_a | cond_b) : (cond_a & cond_b);
      // Loads only count when asked for
      if (is_load && !ctl[`CTL_LOADS_BIT])
        cond = 1'b0;
    end
    else
    begin
      cond_a = ((probe & first_val) == second_val);
      cond_b = ((probe & first_val) != second_val);
      cond   = ctl[`CTL_MODE_BIT] ? cond_b : cond_a;
    end
    hit = valid & ctl[`CTL_ENABLE_BIT] & threads[thread] & cond;
  end

endmodule // dbg_comparator

// file: rtl/dbg_unit.v
`timescale 1ns/100ps
`include "dbg_unit_defines.vh"

// Overview of operation
// - Control bits 23:16 enable each comparator per thread.
// - Control bit 0 is master enable; clear never triggers; resets zero.
// - Four instruction breakpoint control registers.
// - Instruction bit 1: zero breaks on PC equal, one on PC differing.
// - Four 32-bit first data watch addresses.
// - Four 32-bit second data watch addresses.
// - Data control bit 2 lets loads trigger too.
// - Data control bit 1: zero A and B, one A or B.
// - Four 32-bit resource watch masks.
// - Four 32-bit resource watch values.
// - Resource control bit 1 picks condition A or B.
// - Permission bit 31 blocks writes from system switch, scratch path and JTAG.
// - Permission bit 0 blocks writes from system switch only; both reset zero.
// - Writing one to request bit 0 raises a debug interrupt.
// - Request bit 1 reads one in debug mode; resets zero.
// - Cause code 3 instruction, 4 data, 5 resource.
// - Simultaneous hits report instruction over data over resource, lowest-numbered comparator within a kind.
// - Capture effective address or resource id into interrupt data.
module dbg_unit
(
  input  wire        ref_clk,
  input  wire        nrst,
  // Tile configuration port
  input  wire        cfg_wr,
  input  wire        cfg_rd,
  input  wire [1:0]  cfg_src,
  input  wire [7:0]  cfg_addr,
  input  wire [31:0] cfg_wdata,
  output reg  [31:0] cfg_rdata,
  // Processor status (debug) port
  input  wire        ps_wr,
  input  wire        ps_rd,
  input  wire [7:0]  ps_addr,
  input  wire [31:0] ps_wdata,
  output reg  [31:0] ps_rdata,
  // Core probes
  input  wire        pc_valid,
  input  wire [2:0]  pc_thread,
  input  wire [31:0] pc_value,
  input  wire        mem_valid,
  input  wire [2:0]  mem_thread,
  input  wire [31:0] mem_addr,
  input  wire        mem_is_load,
  input  wire        res_valid,
  input  wire [2:0]  res_thread,
  input  wire [31:0] res_id,
  input  wire        debug_mode,
  output reg         debug_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  reg [31:0] ib_addr_r [0:3];
  reg [31:0] ib_ctl_r  [0:3];
  reg [31:0] dw_a1_r   [0:3];
  reg [31:0] dw_a2_r   [0:3];
  reg [31:0] dw_ctl_r  [0:3];
  reg [31:0] rw_mask_r [0:3];
  reg [31:0] rw_val_r  [0:3];
  reg [31:0] rw_ctl_r  [0:3];
  reg        perm_all_r;
  reg        perm_sys_r;
  reg        mode_r;
  reg [2:0]  cause_r;
  reg [7:0]  cause_thread_r;
  reg [1:0]  cause_num_r;
  reg [31:0] int_data_r;

  // Bank decode: hit if addr in base..base+3
  function in_bank;
    input [7:0] addr;
    input [7:0] base;
    begin
      in_bank = (addr[7:2] == base[7:2]) && (addr[1:0] >= base[1:0]);
    end
  endfunction

  function [1:0] bank_idx;
    input [7:0] addr;
    input [7:0] base;
    begin
      bank_idx = addr[1:0] - base[1:0];
    end
  endfunction

  // Index of lowest set bit of four
  function [1:0] low_idx;
    input [3:0] v;
    begin
      low_idx = v[0] ? 2'd0 : v[1] ? 2'd1 : v[2] ? 2'd2 : 2'd3;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Comparators
  wire [3:0] ib_hit;
  wire [3:0] dw_hit;
  wire [3:0] rw_hit;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : cmp
      dbg_comparator #(.KIND(0)) u_ib
      (
        .ctl        (ib_ctl_r[g]),
        .first_val  (ib_addr_r[g]),
        .second_val (32'h00000000),
        .thread     (pc_thread),
        .valid      (pc_valid),
        .probe      (pc_value),
        .is_load    (1'b0),
        .hit        (ib_hit[g])
      );
      dbg_comparator #(.KIND(1)) u_dw
      (
        .ctl        (dw_ctl_r[g]),
        .first_val  (dw_a1_r[g]),
        .second_val (dw_a2_r[g]),
        .thread     (mem_thread),
        .valid      (mem_valid),
        .probe      (mem_addr),
        .is_load    (mem_is_load),
        .hit        (dw_hit[g])
      );
      dbg_comparator #(.KIND(2)) u_rw
      (
        .ctl        (rw_ctl_r[g]),
        .first_val  (rw_mask_r[g]),
        .second_val (rw_val_r[g]),
        .thread     (res_thread),
        .valid      (res_valid),
        .probe      (res_id),
        .is_load    (1'b0),
        .hit        (rw_hit[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Write qualification
  wire cfg_blocked = perm_all_r ? (cfg_src != `SRC_LOCAL)
                                : (perm_sys_r && cfg_src == `SRC_SYSTEM_SWITCH);
  // The permission register obeys its own lock, so once bit 31 is set only a local access can undo it
  wire cfg_we = cfg_wr && !cfg_blocked;
  // Debug registers only change while halted, so a live comparator is never half-written
  wire ps_we  = ps_wr && debug_mode;

  wire any_hit  = |{ib_hit, dw_hit, rw_hit};
  wire host_req = cfg_we && cfg_addr == `CFG_DEBUG_INTERRUPT_REQUEST && cfg_wdata[`REQ_RAISE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  integer i;
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        ib_addr_r[i] <= 32'h00000000;
        ib_ctl_r[i]  <= `CTL_RESET;
        dw_a1_r[i]   <= 32'h00000000;
        dw_a2_r[i]   <= 32'h00000000;
        dw_ctl_r[i]  <= `CTL_RESET;
        rw_mask_r[i] <= 32'h00000000;
        rw_val_r[i]  <= 32'h00000000;
        rw_ctl_r[i]  <= `CTL_RESET;
      end
      perm_all_r     <= 1'b0;
      perm_sys_r     <= 1'b0;
      mode_r         <= 1'b0;
      debug_irq      <= 1'b0;
      cfg_rdata      <= 32'h00000000;
      ps_rdata       <= 32'h00000000;
    end
    else
    begin
      // Request bit 1 mirrors the mode pin one cycle late
      mode_r    <= debug_mode;
      debug_irq <= ((any_hit && !debug_mode) || host_req);
      if (cfg_we && cfg_addr == `CFG_DEBUG_WRITE_PERMISSION)
      begin
        perm_all_r <= cfg_wdata[`PERM_ALL_BIT];
        perm_sys_r <= cfg_wdata[`PERM_SYS_BIT];
      end
      // Reserved control bits are masked here so they always read back zero
      if (ps_we)
      begin
        if (in_bank(ps_addr, `PS_INSTR_BREAK_ADDR))
          ib_addr_r[bank_idx(ps_addr, `PS_INSTR_BREAK_ADDR)] <= ps_wdata;
        if (in_bank(ps_addr, `PS_INSTR_BREAK_CONTROL))
          ib_ctl_r[bank_idx(ps_addr, `PS_INSTR_BREAK_CONTROL)] <= ps_wdata & `IBC_WRITE_MASK;
        if (in_bank(ps_addr, `PS_DATA_WATCH_FIRST_ADDR))
          dw_a1_r[bank_idx(ps_addr, `PS_DATA_WATCH_FIRST_ADDR)] <= ps_wdata;
        if (in_bank(ps_addr, `PS_DATA_WATCH_SECOND_ADDR))
          dw_a2_r[bank_idx(ps_addr, `PS_DATA_WATCH_SECOND_ADDR)] <= ps_wdata;
        if (in_bank(ps_addr, `PS_DATA_WATCH_CONTROL))
          dw_ctl_r[bank_idx(ps_addr, `PS_DATA_WATCH_CONTROL)] <= ps_wdata & `DWC_WRITE_MASK;
        if (in_bank(ps_addr, `PS_RESOURCE_WATCH_MASK))
          rw_mask_r[bank_idx(ps_addr, `PS_RESOURCE_WATCH_MASK)] <= ps_wdata;
        if (in_bank(ps_addr, `PS_RESOURCE_WATCH_VALUE))
          rw_val_r[bank_idx(ps_addr, `PS_RESOURCE_WATCH_VALUE)] <= ps_wdata;
        if (in_bank(ps_addr, `PS_RESOURCE_WATCH_CONTROL))
          rw_ctl_r[bank_idx(ps_addr, `PS_RESOURCE_WATCH_CONTROL)] <= ps_wdata & `RWC_WRITE_MASK;
      end

      // Read data, registered; unmapped reads return zero
      if (cfg_rd)
      begin
        case (cfg_addr)
          `CFG_DEBUG_WRITE_PERMISSION:
            cfg_rdata <= {perm_all_r, 30'h00000000, perm_sys_r};
          `CFG_DEBUG_INTERRUPT_REQUEST:
            cfg_rdata <= {30'h00000000, mode_r, 1'b0};
          default:
            cfg_rdata <= 32'h00000000;
        endcase
      end
      if (ps_rd)
      begin
        if (in_bank(ps_addr, `PS_INSTR_BREAK_ADDR))
          ps_rdata <= ib_addr_r[bank_idx(ps_addr, `PS_INSTR_BREAK_ADDR)];
        else if (in_bank(ps_addr, `PS_INSTR_BREAK_CONTROL))
          ps_rdata <= ib_ctl_r[bank_idx(ps_addr, `PS_INSTR_BREAK_CONTROL)];
        else if (in_bank(ps_addr, `PS_DATA_WATCH_FIRST_ADDR))
          ps_rdata <= dw_a1_r[bank_idx(ps_addr, `PS_DATA_WATCH_FIRST_ADDR)];
        else if (in_bank(ps_addr, `PS_DATA_WATCH_SECOND_ADDR))
          ps_rdata <= dw_a2_r[bank_idx(ps_addr, `PS_DATA_WATCH_SECOND_ADDR)];
        else if (in_bank(ps_addr, `PS_DATA_WATCH_CONTROL))
          ps_rdata <= dw_ctl_r[bank_idx(ps_addr, `PS_DATA_WATCH_CONTROL)];
        else if (in_bank(ps_addr, `PS_RESOURCE_WATCH_MASK))
          ps_rdata <= rw_mask_r[bank_idx(ps_addr, `PS_RESOURCE_WATCH_MASK)];
        else if (in_bank(ps_addr, `PS_RESOURCE_WATCH_VALUE))
          ps_rdata <= rw_val_r[bank_idx(ps_addr, `PS_RESOURCE_WATCH_VALUE)];
        else if (in_bank(ps_addr, `PS_RESOURCE_WATCH_CONTROL))
          ps_rdata <= rw_ctl_r[bank_idx(ps_addr, `PS_RESOURCE_WATCH_CONTROL)];
        else if (ps_addr == `PS_DEBUG_INTERRUPT_TYPE)
          ps_rdata <= {14'h0000, cause_num_r, cause_thread_r, 5'h00, cause_r};
        else if (ps_addr == `PS_DEBUG_INTERRUPT_DATA)
          ps_rdata <= int_data_r;
        else
          ps_rdata <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cause capture
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cause_r        <= 3'h0;
      cause_thread_r <= 8'h00;
      cause_num_r    <= 2'h0;
      int_data_r     <= 32'h00000000;
    end
    else
    begin
      // Hits are ignored in debug mode so the recorded cause survives inspection
      if (any_hit && !debug_mode)
      begin
        if (|ib_hit)
        begin
          cause_r        <= `CAUSE_INSTR;
          cause_num_r    <= low_idx(ib_hit);
          cause_thread_r <= {5'h00, pc_thread};
        end
        else if (|dw_hit)
        begin
          cause_r        <= `CAUSE_DATA;
          cause_num_r    <= low_idx(dw_hit);
          cause_thread_r <= {5'h00, mem_thread};
          int_data_r     <= mem_addr;
        end
        else
        begin
          cause_r        <= `CAUSE_RESOURCE;
          cause_num_r    <= low_idx(rw_hit);
          cause_thread_r <= {5'h00, res_thread};
          int_data_r     <= res_id;
        end
      end
      else if (ps_we && ps_addr == `PS_DEBUG_INTERRUPT_DATA)
        int_data_r <= ps_wdata;
      else if (host_req && !debug_mode)
      begin
        cause_r        <= 3'h1;
        cause_num_r    <= 2'h0;
        cause_thread_r <= 8'h00;
      end
    end
  end

endmodule // dbg_unit

// file: testbench/dbg_unit_props.sv
`timescale 1ns/100ps
module dbg_unit_props
(
  input wire        ref_clk,
  input wire        nrst,
  input wire        cfg_wr,
  input wire        cfg_rd,
  input wire [1:0]  cfg_src,
  input wire [7:0]  cfg_addr,
  input wire [31:0] cfg_wdata,
  input wire [31:0] cfg_rdata,
  input wire        ps_rd,
  input wire [7:0]  ps_addr,
  input wire [31:0] ps_rdata,
  input wire        pc_valid,
  input wire        mem_valid,
  input wire        res_valid,
  input wire        debug_mode,
  input wire        debug_irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////
  host_irq_a: assert property (cfg_wr && cfg_src == 2'h3 && cfg_addr == 8'h05 && cfg_wdata[0]
    |=> debug_irq) else $error("host request gave no pulse");
  irq_cause_a: assert property (debug_irq |-> $past(pc_valid || mem_valid || res_valid || cfg_wr))
    else $error("pulse without a probe or request");
  dbg_quiet_a: assert property (debug_mode && !cfg_wr |=> !debug_irq)
    else $error("hit taken in debug mode");
  // Antecedent needs a steady level since the mode is read one cycle stale
  mode_rd_a: assert property ($past(nrst) && cfg_rd && cfg_addr == 8'h05 && $stable(debug_mode)
    |=> cfg_rdata == {30'h0, $past(debug_mode), 1'b0}) else $error("request register read wrong");
  instr_rsv_a: assert property (ps_rd && ps_addr[7:2] == 6'h10
    |=> ps_rdata[31:24] == 8'h0 && ps_rdata[15:2] == 14'h0) else $error("instr control reserved set");
  data_rsv_a: assert property (ps_rd && ps_addr[7:2] == 6'h1c
    |=> ps_rdata[31:24] == 8'h0 && ps_rdata[15:3] == 13'h0) else $error("data control reserved set");
  res_rsv_a: assert property (ps_rd && ps_addr[7:2] == 6'h27
    |=> ps_rdata[31:24] == 8'h0 && ps_rdata[15:2] == 14'h0) else $error("res control reserved set");
  perm_rsv_a: assert property (cfg_rd && cfg_addr == 8'h04 |=> cfg_rdata[30:1] == 30'h0)
    else $error("permission reserved set");
  cause_code_a: assert property (ps_rd && ps_addr == 8'h15 |=> ps_rdata[31:18] == 14'h0
    && ps_rdata[2:0] inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h5}) else $error("bad cause code");
  rdata_hold_a: assert property (!cfg_rd |=> $stable(cfg_rdata))
    else $error("config read data moved");
endmodule // dbg_unit_props

bind dbg_unit dbg_unit_props u_props (.ref_clk(ref_clk), .nrst(nrst), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_src(cfg_src), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .ps_rd(ps_rd),
  .ps_addr(ps_addr), .ps_rdata(ps_rdata), .pc_valid(pc_valid), .mem_valid(mem_valid),
  .res_valid(res_valid), .debug_mode(debug_mode), .debug_irq(debug_irq));

// file: testbench/core_probe_model.sv
`timescale 1ns/100ps
// Cores: one probe per request, launched just after the rising edge
module core_probe_model
(
  input  wire        ref_clk,
  input  wire        go,
  input  wire [1:0]  kind,
  input  wire [2:0]  thread,
  input  wire [31:0] value,
  input  wire        is_load,
  output reg         pc_valid,
  output reg  [2:0]  pc_thread,
  output reg  [31:0] pc_value,
  output reg         mem_valid,
  output reg  [2:0]  mem_thread,
  output reg  [31:0] mem_addr,
  output reg         mem_is_load,
  output reg         res_valid,
  output reg  [2:0]  res_thread,
  output reg  [31:0] res_id
);
  initial {pc_valid, pc_thread, pc_value, mem_valid, mem_thread, mem_addr, mem_is_load} = 0;
  initial {res_valid, res_thread, res_id} = 0;
  // Idle probes carry inverted junk so a stale value can never match
  always @(posedge ref_clk)
  begin
    pc_valid    <= go && kind == 2'h0;
    mem_valid   <= go && kind == 2'h1;
    res_valid   <= go && kind == 2'h2;
    pc_thread   <= go ? thread : ~pc_thread;
    mem_thread  <= go ? thread : ~mem_thread;
    res_thread  <= go ? thread : ~res_thread;
    pc_value    <= go ? value : ~pc_value;
    mem_addr    <= go ? value : ~mem_addr;
    res_id      <= go ? value : ~res_id;
    mem_is_load <= go ? is_load : ~mem_is_load;
  end
endmodule // core_probe_model

// file: testbench/tb.sv
`timescale 1ns/100ps
`include "dbg_unit_defines.vh"
`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, ex, gt); end end
module tb;
  logic        ref_clk, nrst, cfg_wr, cfg_rd, ps_wr, ps_rd, debug_mode, debug_irq, go, is_load;
  logic        pc_valid, mem_valid, mem_is_load, res_valid;
  logic [1:0]  cfg_src, kind;
  logic [2:0]  thread, pc_thread, mem_thread, res_thread;
  logic [7:0]  cfg_addr, ps_addr;
  logic [31:0] cfg_wdata, cfg_rdata, ps_wdata, ps_rdata, value, rd_v, d, pc_value, mem_addr, res_id;
  logic [31:0] m_reg [0:7][0:3];
  logic [7:0]  bases [0:7] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9c};
  logic [31:0] wmask [0:7] = '{'1, `IBC_WRITE_MASK, '1, '1, `DWC_WRITE_MASK, '1, '1, `RWC_WRITE_MASK};
  integer      err_count, checked, seed, r, b, x, n, s, exp_t;
  dbg_unit u_dut (.*);
  core_probe_model u_cores (.*);
  initial
  begin
    ref_clk = 0;
    forever #4 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checked %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic acc(input p, input w, input [1:0] sr, input [7:0] a, input [31:0] dat);
    @(negedge ref_clk);
    if (p) {ps_wr, ps_rd, ps_addr, ps_wdata} = {w, !w, a, dat};
    else {cfg_wr, cfg_rd, cfg_src, cfg_addr, cfg_wdata} = {w, !w, sr, a, dat};
    @(negedge ref_clk);
    {ps_wr, ps_rd, cfg_wr, cfg_rd} = 4'h0;
    rd_v = p ? ps_rdata : cfg_rdata;
  endtask
  // Reference: lowest index wins, cause 3 + kind, number and thread fields
  function automatic integer predict(input [1:0] k, input [2:0] t, input [31:0] v, input ld);
    logic [31:0] c;
    logic a, bb, m;
    predict = -1;
    for (int i = 3; i >= 0; i--)
    begin
      c = m_reg[k == 0 ? 1 : k == 1 ? 4 : 7][i];
      a = k == 0 ? v == m_reg[0][i] : k == 1 ? v == m_reg[2][i] : (v & m_reg[5][i]) == m_reg[6][i];
      bb = k == 1 ? v == m_reg[3][i] : !a;
      m = k == 0 ? a ^ c[1] : k == 1 ? (c[1] ? a | bb : a & bb) && (!ld || c[2]) : (c[1] ? bb : a);
      if (c[0] && c[16 + t] && m) predict = {i[1:0], 5'h0, t, 5'h0, 3'h3 + {1'b0, k}};
    end
  endfunction
  task automatic readback;
    for (b = 0; b < 8; b++) for (x = 0; x < 4; x++)
    begin
      acc(1, 0, 0, bases[b] + x[7:0], 0);
      `CHK("bank reg", m_reg[b][x], rd_v)
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial
  begin
    #200000;
    err_count++;
    wrap_up;
  end
  initial
  begin
    seed = 32'hd0426d40;
    {err_count, checked, nrst, go, kind, thread, value, is_load, debug_mode} = 0;
    {cfg_wr, cfg_rd, ps_wr, ps_rd, cfg_src, cfg_addr, cfg_wdata, ps_addr, ps_wdata} = 0;
    foreach (m_reg[i, j]) m_reg[i][j] = 0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk) nrst = 1;
    readback;
    acc(0, 0, 0, 8'h04, 0);
    `CHK("perm reset", 32'h0, rd_v)
    acc(1, 1, 0, 8'h40, '1);
    readback;
    $display("test reset done");
    for (r = 0; r < 4; r++)
    begin
      debug_mode = 1;
      for (b = 0; b < 8; b++) for (x = 0; x < 4; x++)
      begin
        d = $random(seed);
        if (wmask[b] === '1) d = d & 32'h3;
        else d[0] = x != 3;
        acc(1, 1, 0, bases[b] + x[7:0], d);
        m_reg[b][x] = d & wmask[b];
      end
      readback;
      for (n = 0; n < 60; n++)
      begin
        debug_mode = n == 59;
        {kind, thread, is_load} = {2'($unsigned($random(seed)) % 3), 3'($random(seed)), 1'($random(seed))};
        value = n[0] ? $random(seed) : $random(seed) & 32'h3;
        @(negedge ref_clk) go = 1;
        @(negedge ref_clk) go = 0;
        @(negedge ref_clk);
        exp_t = debug_mode ? -1 : predict(kind, thread, value, is_load);
        `CHK("irq", exp_t >= 0, debug_irq)
        if (exp_t >= 0)
        begin
          acc(1, 0, 0, 8'h15, 0);
          `CHK("cause", exp_t, rd_v)
          acc(1, 0, 0, 8'h16, 0);
          if (kind != 0) `CHK("data", value, rd_v)
        end
      end
      $display("test round %0d done", r);
    end
    // Mid-run reset while the banks hold random settings
    @(negedge ref_clk) nrst = 0;
    repeat (4) @(negedge ref_clk);
    nrst = 1;
    foreach (m_reg[i, j]) m_reg[i][j] = 0;
    readback;
    acc(1, 0, 0, 8'h15, 0);
    `CHK("cause reset", 32'h0, rd_v)
    $display("test mid reset done");
    debug_mode = 0;
    acc(0, 1, 3, 8'h05, 1);
    `CHK("host irq", 1'b1, debug_irq)
    acc(1, 0, 0, 8'h15, 0);
    `CHK("host cause", 32'h1, rd_v)
    foreach (wmask[p]) if (p < 2)
    begin
      acc(0, 1, 3, 8'h04, p ? 32'h80000000 : 32'h1);
      acc(0, 0, 0, 8'h04, 0);
      `CHK("perm", p ? 32'h80000000 : 32'h1, rd_v)
      for (s = 0; s < 4; s++)
      begin
        acc(0, 1, s[1:0], 8'h05, 1);
        `CHK("blocked irq", p ? s == 3 : s != 0, debug_irq)
      end
      acc(0, 1, 3, 8'h04, 0);
    end
    debug_mode = 1;
    repeat (2) @(negedge ref_clk);
    acc(0, 0, 0, 8'h05, 0);
    `CHK("mode", 32'h2, rd_v)
    acc(1, 1, 0, 8'h16, 32'h5a5a0f0f);
    acc(1, 0, 0, 8'h16, 0);
    `CHK("data write", 32'h5a5a0f0f, rd_v)
    $display("test config done");
    wrap_up;
  end
endmodule // tb
